//--- rtl/feature_element_inquiry_regs.sv
// Read-only bank of brightness, white balance and shutter capability words.
// Assumes all inputs are synchronous to mclk_i; the variant strap is
// stable around reset release.
module feature_element_inquiry_regs #(
	parameter int LIMIT_BITS = 12
) (
	// Clock, reset, enable
	input  wire logic                        mclk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        ce_i,
	// Host register access
	input  wire logic [47:0]                 addr_i,
	input  wire logic                        rd_i,
	input  wire logic                        wr_i,
	input  wire logic [31:0]                 wdata_i,
	output logic      [31:0]                 rdata_o,
	output logic                             ack_o,
	// Variant and active video settings
	input  wire logic                        colour_variant_i,
	input  wire feature_inquiry_pkg::video_format_e format_i,
	input  wire logic [LIMIT_BITS-1:0]       fixed_shutter_max_i
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (LIMIT_BITS != feature_inquiry_pkg::LIMIT_W) begin : g_bad_width
		$error("LIMIT_BITS must match the 12-bit limit fields");
	end

	// ------------------------------------------------------------
	// Word construction
	// ------------------------------------------------------------
	// Common flag set: present, readable, manual; all other modes off
	function automatic feature_inquiry_pkg::cap_word_s manual_word(
		input logic [11:0] lo,
		input logic [11:0] hi
	);
		feature_inquiry_pkg::cap_word_s w;
		w           = '0;
		w.present   = 1'b1;
		w.read_out  = 1'b1;
		w.manual    = 1'b1;
		w.reserved  = 1'b0;
		w.min_limit = lo;
		w.max_limit = hi;
		return w;
	endfunction : manual_word

	logic           colour_reg;
	logic           colour_next;
	logic           strap_done_reg;
	logic           strap_done_next;
	logic [31:0]    rdata_reg;
	logic [31:0]    rdata_next;
	logic           ack_reg;
	logic           ack_next;
	logic           hit;
	logic [11:0]    offset;
	logic [11:0]    shutter_max;
	feature_inquiry_pkg::cap_word_s bright_w;
	feature_inquiry_pkg::cap_word_s wb_w;
	feature_inquiry_pkg::cap_word_s shutter_w;

	// Decode against the control base; low bits form the byte offset
	assign hit    = addr_i[47:12] == feature_inquiry_pkg::CSR_BASE_ADDR[47:12];
	assign offset = addr_i[11:0] - feature_inquiry_pkg::CSR_BASE_ADDR[11:0];

	// Live words, rebuilt every cycle so a format change shows at once
	always_comb begin
		bright_w = manual_word(feature_inquiry_pkg::BRIGHT_MIN,
			feature_inquiry_pkg::BRIGHT_MAX);
		wb_w = colour_reg ? manual_word(feature_inquiry_pkg::WB_MIN,
			feature_inquiry_pkg::WB_MAX) : '0;
		if (format_i == feature_inquiry_pkg::FMT_SCALABLE) begin
			shutter_max = feature_inquiry_pkg::SHUTTER_MAX_SCAL;
		end else begin
			shutter_max = fixed_shutter_max_i;
		end
		shutter_w = manual_word(feature_inquiry_pkg::SHUTTER_MIN,
			shutter_max);
	end

	// ------------------------------------------------------------
	// Variant strap and read port
	// ------------------------------------------------------------
	// Strap taken once after reset release, never inside the reset
	always_comb begin
		colour_next     = colour_reg;
		strap_done_next = 1'b1;
		if (!strap_done_reg) begin
			colour_next = colour_variant_i;
		end
		rdata_next = rdata_reg;
		ack_next   = 1'b0;
		if (hit && (rd_i || wr_i)) begin
			ack_next = 1'b1;
		end
		// Writes are answered but never stored: nothing to alter here
		if (hit && rd_i) begin
			case (offset)
				feature_inquiry_pkg::BRIGHTNESS_OFFSET: rdata_next = bright_w;
				feature_inquiry_pkg::WHITE_BAL_OFFSET:  rdata_next = wb_w;
				feature_inquiry_pkg::SHUTTER_OFFSET:    rdata_next = shutter_w;
				default: rdata_next = feature_inquiry_pkg::READ_RESET_VALUE;
			endcase
		end
	end

	// Registers; ce_i low freezes every register, but reset_n_i still clears them
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			colour_reg     <= 1'b0;
			strap_done_reg <= 1'b0;
			rdata_reg      <= feature_inquiry_pkg::READ_RESET_VALUE;
			ack_reg        <= 1'b0;
		end else if (ce_i) begin
			colour_reg     <= colour_next;
			strap_done_reg <= strap_done_next;
			rdata_reg      <= rdata_next;
			ack_reg        <= ack_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign ack_o   = ack_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic unused_wdata;
	assign unused_wdata = ^wdata_i;

	chk_bright_word: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h500) |=>
		rdata_o == 32'h0FF0_0091)
		else $error("brightness word wrong");

	chk_bright_limits: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h500) |=>
		(rdata_o[31:20] == 12'd255 && rdata_o[19:8] == 12'd0))
		else $error("brightness limits wrong");

	chk_wb_mono: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h50C && strap_done_reg
		&& !colour_reg) |=> rdata_o == 32'h0)
		else $error("mono white balance not zero");

	chk_wb_colour: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h50C && colour_reg) |=>
		rdata_o == 32'h0FF0_1091)
		else $error("colour white balance wrong");

	chk_shutter_flags: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h51C) |=>
		(rdata_o[7:0] == 8'h91 && rdata_o[19:8] == 12'd1))
		else $error("shutter flags or minimum wrong");

	chk_shutter_scal: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h51C
		&& format_i == feature_inquiry_pkg::FMT_SCALABLE) |=>
		rdata_o[31:20] == 12'd4095)
		else $error("scalable shutter maximum wrong");

	chk_shutter_fixed: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h51C
		&& format_i == feature_inquiry_pkg::FMT_FIXED) |=>
		rdata_o[31:20] == $past(fixed_shutter_max_i))
		else $error("fixed shutter maximum not tracked");

	chk_write_ignored: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && wr_i && !rd_i) |=> $stable(rdata_o))
		else $error("write altered read data");

	chk_reserved_zero: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		rdata_o[2] == 1'b0)
		else $error("reserved bit set");

	// Decode judged on the address of the request edge, not the next one
	chk_ack_decode: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && (rd_i || wr_i)) |=>
		ack_o == ($past(addr_i[47:12]) == 36'hFFFF_F0F00))
		else $error("ack does not follow base decode");

	chk_present_flag: assert property (
		@(posedge mclk_i) disable iff (!reset_n_i)
		(ce_i && rd_i && hit && offset == 12'h50C) |=>
		rdata_o[0] == $past(colour_reg))
		else $error("presence flag wrong");

endmodule : feature_element_inquiry_regs

//--- pkg/feature_inquiry_pkg.sv
// Constants, field layout and word type of the feature capability words.
// Assumes a host-side decoder presenting byte addresses on one clock.
package feature_inquiry_pkg;

	// ------------------------------------------------------------
	// Addressing
	// ------------------------------------------------------------
	localparam logic [47:0] CSR_BASE_ADDR     = 48'hFFFF_F0F0_0000;
	localparam int          OFFSET_W          = 12;
	localparam logic [11:0] BRIGHTNESS_OFFSET = 12'h500;
	localparam logic [11:0] WHITE_BAL_OFFSET  = 12'h50C;
	localparam logic [11:0] SHUTTER_OFFSET    = 12'h51C;

	// ------------------------------------------------------------
	// Field positions and limit values
	// ------------------------------------------------------------
	localparam int          PRESENT_BIT      = 0;
	localparam int          RESERVED_BIT     = 2;
	localparam int          MIN_LSB          = 8;
	localparam int          MAX_LSB          = 20;
	localparam int          LIMIT_W          = 12;
	localparam logic [11:0] BRIGHT_MIN       = 12'h000;
	localparam logic [11:0] BRIGHT_MAX       = 12'h0FF;
	localparam logic [11:0] WB_MIN           = 12'h010;
	localparam logic [11:0] WB_MAX           = 12'h0FF;
	localparam logic [11:0] SHUTTER_MIN      = 12'h001;
	localparam logic [11:0] SHUTTER_MAX_SCAL = 12'hFFF;
	localparam logic [31:0] READ_RESET_VALUE = 32'h0000_0000;

	// One capability word, most significant field first
	typedef struct packed {
		logic [11:0] max_limit;
		logic [11:0] min_limit;
		logic        manual;
		logic        auto_mode;
		logic        on_off;
		logic        read_out;
		logic        one_push;
		logic        reserved;
		logic        abs_ctl;
		logic        present;
	} cap_word_s;

	// Video format selection
	typedef enum logic [0:0] {
		FMT_FIXED    = 1'b0,
		FMT_SCALABLE = 1'b1
	} video_format_e;

endpackage : feature_inquiry_pkg

//--- verif/host_model.sv
// Host side model: issues single-word capability register accesses.
// Assumes one caller at a time; requests launch on the falling edge.
module host_model (
	// Clock and answer from the block
	input  wire logic        mclk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] rdata_i,
	// Request lines
	output logic      [47:0] addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [31:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial begin
		addr_o  = 48'h0;
		rd_o    = 1'b0;
		wr_o    = 1'b0;
		wdata_o = 32'h0;
	end

	// One-edge request pulse, then a bounded wait for the acknowledge
	task automatic access(input logic w, input logic [47:0] a,
		output logic [31:0] d, output logic ok);
		ok = 1'b0;
		d = 32'h0;
		@(negedge mclk_i);
		addr_o  = a;
		rd_o    = ~w;
		wr_o    = w;
		wdata_o = $urandom;
		@(negedge mclk_i);
		rd_o    = 1'b0;
		wr_o    = 1'b0;
		addr_o  = ~a; // Released lines must not keep the old value
		wdata_o = ~wdata_o;
		for (int k = 0; k < 4 && !ok; k++) begin
			if (ack_i === 1'b1) begin
				ok = 1'b1;
				d = rdata_i;
			end else begin
				@(negedge mclk_i);
			end
		end
	endtask : access
endmodule : host_model

//--- verif/feature_element_inquiry_regs_test.sv
// Self-checking bench for the capability register bank.
// Assumes host_model drives the request side; ce_i mostly high.
module feature_element_inquiry_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [47:0] BASE = feature_inquiry_pkg::CSR_BASE_ADDR;
	logic        mclk_i    = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        colour    = 1'b0;
	logic        ce        = 1'b1;
	logic [31:0] prev      = 32'h0;
	logic        ok;
	logic        rd;
	logic        wr;
	logic        ack;
	logic [11:0] smax      = 12'h0;
	logic [11:0] off;
	logic [31:0] rdata;
	logic [31:0] wdata;
	logic [31:0] got;
	logic [47:0] addr;
	int          miscompares = 0;
	int          checks      = 0;
	feature_inquiry_pkg::video_format_e fmt = feature_inquiry_pkg::FMT_FIXED;

	// 40 MHz clock
	initial forever #12.5 mclk_i = ~mclk_i;

	host_model host (.mclk_i(mclk_i), .ack_i(ack), .rdata_i(rdata),
		.addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

	feature_element_inquiry_regs #(.LIMIT_BITS(12)) uut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce),
		.addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
		.rdata_o(rdata), .ack_o(ack), .colour_variant_i(colour),
		.format_i(fmt), .fixed_shutter_max_i(smax));

	// Expected word from variant, format and shutter limit
	function automatic logic [31:0] expected(input logic [11:0] o);
		case (o)
			12'h500: expected = 32'h0FF0_0091;
			12'h50C: expected = colour ? 32'h0FF0_1091 : 32'h0;
			12'h51C: expected = {(fmt == feature_inquiry_pkg::FMT_SCALABLE) ?
				12'hFFF : smax, 20'h00191};
			default: expected = 32'h0;
		endcase
	endfunction : expected

	// Compare and count
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check

	// Verdict and end of run
	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Main sequence: both variants, random format and offsets
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32669));
		for (int v = 0; v < 2; v++) begin
			@(negedge mclk_i);
			reset_n_i = 1'b0;
			colour = v[0];
			prev = 32'h0; // Read data clears in reset
			repeat (20) @(negedge mclk_i);
			reset_n_i = 1'b1;
			repeat (2) @(negedge mclk_i); // Strap capture edge first
			for (int i = 0; i < 40; i++) begin
				fmt = feature_inquiry_pkg::video_format_e'($urandom_range(1));
				smax = 12'($urandom);
				case (i % 4)
					0: off = 12'h500;
					1: off = 12'h50C;
					2: off = 12'h51C;
					default: off = 12'($urandom) & 12'hFFC;
				endcase
				if (i % 3 == 0) begin
					host.access(1'b1, BASE | 48'(off), got, ok);
					check(32'(ok), 32'h1);
					check(got, prev);
				end
				host.access(1'b0, BASE | 48'(off), got, ok);
				check(32'(ok), 32'h1);
				if (ok !== 1'b1)
					stop_test();
				check(got, expected(off));
				prev = expected(off);
				host.access(1'b0, {~BASE[47:12], off}, got, ok);
				check(32'(ok), 32'h0);
				// Frozen block: no answer, read data kept
				if (i % 8 == 7) begin
					ce = 1'b0;
					host.access(1'b0, BASE | 48'(off), got, ok);
					check(32'(ok), 32'h0);
					check(rdata, prev);
					ce = 1'b1;
				end
			end
		end
		stop_test();
	end
endmodule : feature_element_inquiry_regs_test
